// file: shared/switch_global_control_pkg.sv
// package: register map, field layout, reset values and aging timing
package switch_global_control_pkg;
  // register byte offsets (printed offsets are not all multiples of four: index times four)
  localparam logic [7:0] IDX_GC_FIRST = 8'h02;
  localparam logic [7:0] IDX_GC_SECOND = 8'h03;
  localparam logic [7:0] IDX_AGE_STATUS = 8'h04;
  localparam logic [9:0] ADDR_GC_FIRST = {IDX_GC_FIRST, 2'b00};
  localparam logic [9:0] ADDR_GC_SECOND = {IDX_GC_SECOND, 2'b00};
  localparam logic [9:0] ADDR_AGE_STATUS = {IDX_AGE_STATUS, 2'b00};
  localparam int ADDR_W = 10;
  // first register fields
  localparam int B_ALT_BACKOFF = 7;
  localparam int B_FC_PASS = 3;
  localparam int B_LINK_AGE = 0;
  // second register fields
  localparam int B_PASS_ALL = 7;
  localparam int B_TX_FC = 5;
  localparam int B_RX_FC = 4;
  localparam int B_LEN_CHECK = 3;
  localparam int B_AGE_EN = 2;
  localparam int B_FAST_AGE = 1;
  localparam int B_AGGR_BACKOFF = 0;
  // reset values; aging enable bit is replaced from the strap
  localparam logic [7:0] RST_GC_FIRST = 8'h44;
  localparam logic [7:0] RST_GC_SECOND = 8'h30;
  // frame length check threshold
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05dc;
  // aging timing at 100 MHz
  localparam longint CLK_HZ = 100000000;
  localparam longint FAST_AGE_US = 800;
  localparam longint NORMAL_AGE_S = 200;
  // longest time: round down
  localparam longint FAST_AGE_CYC = (FAST_AGE_US * CLK_HZ) / 1000000;
  localparam longint NORMAL_AGE_CYC = NORMAL_AGE_S * CLK_HZ;
  localparam int PORTS = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {AGE_NORMAL, AGE_FAST, AGE_LINK_PASS} age_mode_e;
endpackage

// file: hw/age_timer.sv
// aging tick generator: normal, fast and one-shot link-change pass
`timescale 1ns/10ps
module age_timer
  import switch_global_control_pkg::*;
#(
  parameter logic [34:0] NORMAL_CYC = 35'(NORMAL_AGE_CYC),
  parameter logic [34:0] FAST_CYC = 35'(FAST_AGE_CYC)
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic age_en,
  input wire logic fast_en,
  input wire logic link_pass_start,
  input wire logic flush_all,
  // results
  output logic age_tick,
  output logic flush_tick,
  output logic link_pass_busy
);
  logic [34:0] cnt_reg;
  logic busy_reg;
  logic tick_reg;
  logic flush_reg;
  logic [34:0] period;

  assign period = (fast_en || busy_reg) ? FAST_CYC : NORMAL_CYC;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (!age_en || link_pass_start)
      cnt_reg <= '0;
    else if (cnt_reg >= period - 35'd1)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 35'd1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_reg <= 1'b0;
    else
      tick_reg <= age_en && !link_pass_start && (cnt_reg >= period - 35'd1);
  end

  // one fast pass after link loss, then back to normal period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_reg <= 1'b0;
    else if (link_pass_start && age_en)
      busy_reg <= 1'b1;
    else if (busy_reg && (tick_reg || !age_en))
      busy_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flush_reg <= 1'b0;
    else
      flush_reg <= flush_all;
  end

  assign age_tick = tick_reg;
  assign flush_tick = flush_reg;
  assign link_pass_busy = busy_reg;
endmodule

// file: hw/switch_global_control.sv
// global control registers: back-off, flow control, filtering and aging control
`timescale 1ns/10ps
// Notes on behaviour
// - bit 7 of first register selects the alternative back-off algorithm
// - flow-control pass bit forwards flow-control frames, else they are discarded
// - link loss with link-change aging starts one fast pass, then normal
// - any port losing its cable ages out the whole address table
// - pass-all forwards errored frames, only while sniffer mode is active
// - transmit flow-control bit clear means no PAUSE frames generated
// - receive flow-control bit clear means received PAUSE frames ignored
// - length check drops frames with Length/Type below 1500 and mismatching
// - aging enable resets to inverse of strap pin sampled during reset
// - fast-age bit shortens aging period to about 800 us
// - aggressive back-off bit makes half-duplex ports back off aggressively
module switch_global_control
  import switch_global_control_pkg::*;
#(
  parameter logic [34:0] NORMAL_CYC = 35'(NORMAL_AGE_CYC),
  parameter logic [34:0] FAST_CYC = 35'(FAST_AGE_CYC)
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // strap and link state pins
  input wire logic aging_strap_pin,
  input wire logic [PORTS-1:0] port_link_up,
  // datapath status
  input wire logic sniffer_active,
  // frame classification from the datapath
  input wire logic frame_is_fc,
  input wire logic frame_is_errored,
  input wire logic [15:0] frame_len_type,
  input wire logic [15:0] frame_payload_len,
  // controls to the datapath
  output logic alt_backoff,
  output logic aggr_backoff,
  output logic pause_tx_en,
  output logic pause_rx_en,
  output logic frame_drop,
  // aging controls to the address table
  output logic age_tick,
  output logic age_flush,
  output logic link_pass_busy
);
  logic [7:0] gc_first_reg;
  logic [7:0] gc_second_reg;
  logic [1:0] strap_rst_reg;
  logic [PORTS-1:0] link_s1_reg;
  logic [PORTS-1:0] link_s2_reg;
  logic [PORTS-1:0] link_prev_reg;
  logic strap_loaded_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic link_lost;
  logic do_write;
  logic len_mismatch;
  logic pass_all;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_s1_reg <= '0;
      link_s2_reg <= '0;
    end
    else
    begin
      link_s1_reg <= port_link_up;
      link_s2_reg <= link_s1_reg;
    end
  end

  // strap keeps sampling during reset; pin internally pulled down
  always_ff @(posedge aclk)
  begin
    strap_rst_reg <= {strap_rst_reg[0], aging_strap_pin};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      link_prev_reg <= '0;
    else
      link_prev_reg <= link_s2_reg;
  end

  assign link_lost = |(link_prev_reg & ~link_s2_reg);

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (awaddr_reg == ADDR_GC_FIRST || awaddr_reg == ADDR_GC_SECOND ||
                    awaddr_reg == ADDR_AGE_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gc_first_reg <= RST_GC_FIRST;
    else if (do_write && awaddr_reg == ADDR_GC_FIRST && wstrb_reg[0])
      gc_first_reg <= wdata_reg[7:0];
  end

  // aging enable default is loaded once after reset from the strap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gc_second_reg <= RST_GC_SECOND;
      strap_loaded_reg <= 1'b0;
    end
    else if (!strap_loaded_reg)
    begin
      gc_second_reg[B_AGE_EN] <= ~strap_rst_reg[1];
      strap_loaded_reg <= 1'b1;
    end
    else if (do_write && awaddr_reg == ADDR_GC_SECOND && wstrb_reg[0])
      gc_second_reg <= wdata_reg[7:0];
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_GC_FIRST: rdata_reg <= {24'h000000, gc_first_reg};
        ADDR_GC_SECOND: rdata_reg <= {24'h000000, gc_second_reg};
        ADDR_AGE_STATUS: rdata_reg <= {30'h0, strap_loaded_reg, link_pass_busy};
        default:
        begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ------------------------------------------------------------
  // datapath controls
  // ------------------------------------------------------------
  assign alt_backoff = gc_first_reg[B_ALT_BACKOFF];
  assign aggr_backoff = gc_second_reg[B_AGGR_BACKOFF];
  assign pause_tx_en = gc_second_reg[B_TX_FC];
  assign pause_rx_en = gc_second_reg[B_RX_FC];
  assign pass_all = gc_second_reg[B_PASS_ALL] && sniffer_active;

  assign len_mismatch = gc_second_reg[B_LEN_CHECK] && (frame_len_type < LEN_TYPE_LIMIT) &&
                        (frame_len_type != frame_payload_len);

  assign frame_drop = !pass_all &&
                      ((frame_is_fc && !gc_first_reg[B_FC_PASS]) || frame_is_errored || len_mismatch);

  // ------------------------------------------------------------
  // aging
  // ------------------------------------------------------------
  age_timer #(
    .NORMAL_CYC(NORMAL_CYC),
    .FAST_CYC(FAST_CYC)
  ) u_age_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .age_en(gc_second_reg[B_AGE_EN]),
    .fast_en(gc_second_reg[B_FAST_AGE]),
    .link_pass_start(link_lost && gc_first_reg[B_LINK_AGE]),
    .flush_all(link_lost),
    .age_tick(age_tick),
    .flush_tick(age_flush),
    .link_pass_busy(link_pass_busy)
  );
endmodule

// file: sim/switch_global_control_chk.sv
// checker: filter, register and aging assertions
`timescale 1ns/10ps
module switch_global_control_chk
  import switch_global_control_pkg::*;
#(
  parameter logic [34:0] FAST_CYC = 35'h14
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // inputs
  input wire logic s_axi_bvalid,
  input wire logic [PORTS-1:0] port_link_up,
  input wire logic sniffer_active,
  input wire logic frame_is_fc,
  input wire logic frame_is_errored,
  input wire logic [15:0] frame_len_type,
  // outputs
  input wire logic alt_backoff,
  input wire logic aggr_backoff,
  input wire logic pause_tx_en,
  input wire logic pause_rx_en,
  input wire logic frame_drop,
  input wire logic age_tick,
  input wire logic age_flush,
  input wire logic link_pass_busy
);
  logic [34:0] busy_cnt_reg;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // --------------------------------
  // fast pass length counter
  // --------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !link_pass_busy)
      busy_cnt_reg <= '0;
    else
      busy_cnt_reg <= busy_cnt_reg + 35'h1;
  end
  drop_clean_a:
  assert property (!frame_is_fc && !frame_is_errored && frame_len_type >= LEN_TYPE_LIMIT |-> !frame_drop)
    else $error("clean frame dropped");
  err_drop_a:
  assert property (frame_is_errored && !sniffer_active |-> frame_drop)
    else $error("errored frame passed");
  ctrl_hold_a:
  assert property (!$stable({alt_backoff, aggr_backoff, pause_tx_en, pause_rx_en}) |-> $rose(s_axi_bvalid))
    else $error("control changed without write");
  rst_ctrl_a:
  assert property ($rose(aresetn) |-> pause_tx_en && pause_rx_en && !alt_backoff && !aggr_backoff)
    else $error("control reset value wrong");
  tick_pulse_a:
  assert property (age_tick |=> !age_tick)
    else $error("aging tick too long");
  flush_link_a:
  assert property (|($past(port_link_up) & ~port_link_up) |-> ##[2:6] age_flush)
    else $error("no flush after link loss");
  flush_pulse_a:
  assert property (age_flush |=> !age_flush)
    else $error("flush pulse too long");
  busy_len_a:
  assert property (busy_cnt_reg <= FAST_CYC + 35'h8)
    else $error("fast pass too long");
  cover property (age_flush ##[1:4] link_pass_busy);
  cover property (frame_drop && frame_is_errored);
  cover property ($rose(s_axi_bvalid));
endmodule

// file: sim/switch_global_control_test.sv
// testbench: register access, frame filter and aging
`timescale 1ns/10ps
module switch_global_control_test
  import switch_global_control_pkg::*;
;
  localparam int N_CYC = 200;
  localparam int F_CYC = 20;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic aging_strap_pin = 1'h0, sniffer_active = 1'h0, frame_is_fc = 1'h0, frame_is_errored = 1'h0;
  logic [PORTS-1:0] port_link_up = 3'h7;
  logic [15:0] frame_len_type = 16'h0, frame_payload_len = 16'h0;
  logic alt_backoff, aggr_backoff, pause_tx_en, pause_rx_en, frame_drop, age_tick, age_flush, link_pass_busy;
  logic [31:0] seed = 32'h13454;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 aclk = ~aclk;
  switch_global_control #(.NORMAL_CYC(35'(N_CYC)), .FAST_CYC(35'(F_CYC))) u_switch_global_control (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .aging_strap_pin(aging_strap_pin), .port_link_up(port_link_up), .sniffer_active(sniffer_active),
    .frame_is_fc(frame_is_fc), .frame_is_errored(frame_is_errored), .frame_len_type(frame_len_type),
    .frame_payload_len(frame_payload_len), .alt_backoff(alt_backoff), .aggr_backoff(aggr_backoff),
    .pause_tx_en(pause_tx_en), .pause_rx_en(pause_rx_en), .frame_drop(frame_drop), .age_tick(age_tick),
    .age_flush(age_flush), .link_pass_busy(link_pass_busy));
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_drop(input logic [7:0] f, input logic [7:0] s);
    return !(s[B_PASS_ALL] && sniffer_active) && ((frame_is_fc && !f[B_FC_PASS]) || frame_is_errored
      || (s[B_LEN_CHECK] && frame_len_type < LEN_TYPE_LIMIT && frame_len_type != frame_payload_len));
  endfunction
  function automatic logic pick(input int k);
    return k == 0 ? age_tick : k == 1 ? age_flush : k == 2 ? link_pass_busy : !link_pass_busy;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_on(input int k, input int lim, input logic want, output int n);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (pick(k) !== 1'h1 && n < lim);
    chk(34'(pick(k)), 34'(want));
    if (pick(k) !== want)
      print_verdict();
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [33:0] got);
    int n;
    logic ha, hw, hd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    hd = 1'h0;
    for (n = 0; n < 50 && !hd; n++)
    begin
      @(negedge aclk);
      ha = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      hw = s_axi_wvalid && s_axi_wready;
      hd = w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1;
      got = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ha)
      begin
        s_axi_awvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (hw)
        s_axi_wvalid <= 1'h0;
      if (hd)
      begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
      end
    end
    if (!hd)
    begin
      chk(34'(hd), 34'h1);
      print_verdict();
    end
  endtask
  task automatic do_reset(input logic st);
    @(posedge aclk);
    aging_strap_pin <= st;
    aresetn <= 1'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    logic [33:0] g;
    logic [7:0] f, s;
    logic [31:0] x;
    int n;
    do_reset(1'h0);
    bus(1'h0, ADDR_GC_FIRST, 8'h0, g);
    chk(g, {24'h0, RST_GC_FIRST, RESP_OKAY});
    bus(1'h0, ADDR_GC_SECOND, 8'h0, g);
    chk(g, {24'h0, RST_GC_SECOND | 8'h04, RESP_OKAY});
    bus(1'h1, 10'h3fc, 8'hff, g);
    chk(g, {32'h0, RESP_SLVERR});
    bus(1'h0, 10'h3fc, 8'h0, g);
    chk(g, {32'h0, RESP_SLVERR});
    repeat (10)
    begin
      x = rnd();
      f = (x[7:0] & 8'h88) | 8'h44;
      s = x[15:8] & 8'hbf;
      bus(1'h1, ADDR_GC_FIRST, f, g);
      chk(g, {32'h0, RESP_OKAY});
      bus(1'h1, ADDR_GC_SECOND, s, g);
      bus(1'h0, ADDR_GC_FIRST, 8'h0, g);
      chk(g, {24'h0, f, RESP_OKAY});
      bus(1'h0, ADDR_GC_SECOND, 8'h0, g);
      chk(g, {24'h0, s, RESP_OKAY});
      chk(34'({alt_backoff, aggr_backoff, pause_tx_en, pause_rx_en}), 34'({f[7], s[0], s[5], s[4]}));
      repeat (4)
      begin
        @(posedge aclk);
        x = rnd();
        sniffer_active <= x[2];
        frame_is_errored <= x[1];
        frame_is_fc <= x[0];
        frame_len_type <= 16'h05d8 + 16'(x[7:4]);
        frame_payload_len <= 16'h05d8 + 16'(x[7:4]) + 16'(x[8]);
        @(negedge aclk);
        chk(34'(frame_drop), 34'(exp_drop(f, s)));
      end
    end
    s_axi_wstrb <= 4'he;
    bus(1'h1, ADDR_GC_FIRST, 8'h00, g);
    chk(g, {32'h0, RESP_OKAY});
    s_axi_wstrb <= 4'hf;
    bus(1'h0, ADDR_GC_FIRST, 8'h0, g);
    chk(g, {24'h0, f, RESP_OKAY});
    bus(1'h1, ADDR_GC_SECOND, 8'h36, g);
    wait_on(0, N_CYC + 5, 1'h1, n);
    wait_on(0, N_CYC + 5, 1'h1, n);
    chk(34'(n >= F_CYC - 1 && n <= F_CYC + 1), 34'h1);
    bus(1'h1, ADDR_GC_SECOND, 8'h34, g);
    wait_on(0, N_CYC + 5, 1'h1, n);
    wait_on(0, N_CYC + 5, 1'h1, n);
    chk(34'(n >= N_CYC - 1 && n <= N_CYC + 1), 34'h1);
    bus(1'h1, ADDR_GC_FIRST, 8'h45, g);
    @(posedge aclk);
    port_link_up <= 3'h5;
    wait_on(1, 10, 1'h1, n);
    wait_on(2, 10, 1'h1, n);
    bus(1'h0, ADDR_AGE_STATUS, 8'h0, g);
    chk(g, {32'h3, RESP_OKAY});
    wait_on(3, F_CYC + 10, 1'h1, n);
    wait_on(0, N_CYC + 5, 1'h1, n);
    chk(34'(n >= N_CYC - 3 && n <= N_CYC + 2), 34'h1);
    bus(1'h1, ADDR_GC_SECOND, 8'h30, g);
    repeat (3) @(negedge aclk);
    wait_on(0, N_CYC + 50, 1'h0, n);
    do_reset(1'h1);
    bus(1'h0, ADDR_GC_SECOND, 8'h0, g);
    chk(g, {24'h0, RST_GC_SECOND, RESP_OKAY});
    bus(1'h0, ADDR_GC_FIRST, 8'h0, g);
    chk(g, {24'h0, RST_GC_FIRST, RESP_OKAY});
    print_verdict();
  end
endmodule
bind switch_global_control switch_global_control_chk #(.FAST_CYC(FAST_CYC)) u_switch_global_control_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .port_link_up(port_link_up),
  .sniffer_active(sniffer_active), .frame_is_fc(frame_is_fc), .frame_is_errored(frame_is_errored),
  .frame_len_type(frame_len_type), .alt_backoff(alt_backoff), .aggr_backoff(aggr_backoff),
  .pause_tx_en(pause_tx_en), .pause_rx_en(pause_rx_en), .frame_drop(frame_drop), .age_tick(age_tick),
  .age_flush(age_flush), .link_pass_busy(link_pass_busy));
